// [rtl/psf_frontend.sv]
// Processor-bus slave front end: decode, parity, policy and data buffering
`timescale 1ns/1ps
module psf_frontend (
  input wire logic clk_sys,
  input wire logic rst_n,
  // Processor bus
  input wire logic address_strobe_n,
  input wire logic transfer_start_n,
  input wire logic register_select_n,
  input wire logic pci_window_select_n,
  input wire logic image_select,
  input wire logic burst_n,
  input wire logic read_n_write,
  input wire logic [31:0] addr,
  input wire logic [3:0] byte_en,
  input wire logic [31:0] wdata,
  input wire logic [3:0] byte_parity_lines_in,
  input wire logic data_valid,
  output logic [31:0] rdata,
  output logic [3:0] byte_parity_lines_out,
  output logic byte_parity_lines_oe,
  output logic wr_ack,
  output logic rd_ack,
  input wire logic slave_protocol_strap,
  // Configuration and status bits
  input wire logic parity_polarity_select,
  input wire logic proc_parity_err_irq_enable,
  input wire logic proc_parity_err_irq_route,
  input wire logic proc_parity_err_clear,
  output logic proc_parity_err_flag,
  output logic pci_irq,
  output logic proc_side_irq,
  output logic [1:0] slave_protocol,
  input wire psf_pkg::psf_image_t image0,
  input wire psf_pkg::psf_image_t image1,
  // Request toward the PCI master
  output logic req_valid,
  input wire logic req_ready,
  output psf_pkg::psf_req_t req,
  input wire logic delayed_write_done,
  // Posted-write data toward the PCI master
  output logic pw_valid,
  input wire logic pw_ready,
  output psf_pkg::psf_word_t pw_word,
  output logic [6:0] pw_level,
  // Read data from the PCI master
  input wire logic rr_valid,
  output logic rr_ready,
  input wire psf_pkg::psf_word_t rr_word
);
  // ==========================================================================
  // Strap capture
  logic strap_taken;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      strap_taken <= 1'b0;
      slave_protocol <= psf_pkg::PROTO_RESET;
    end else if (!strap_taken) begin
      // First edge after release samples the pin; a constant under reset
      strap_taken <= 1'b1;
      slave_protocol <= slave_protocol_strap ? psf_pkg::PSF_PROTO_STROBE_TS860
                                             : psf_pkg::PSF_PROTO_STROBE_TS040;
    end
  end

  // ==========================================================================
  // Cycle decode
  typedef enum logic [1:0] {
    PSF_IDLE = 2'b00,
    PSF_DECODE = 2'b01,
    PSF_HOLD = 2'b11,
    PSF_DATA = 2'b10
  } psf_state_t;

  psf_state_t state;
  psf_pkg::psf_image_t img;
  psf_pkg::psf_req_t next_req;
  logic start;
  logic any_sel;
  logic is_write;
  logic is_burst;
  logic cur_write;
  logic cur_delayed;
  logic dw_pending;
  logic next_delayed;
  logic accept;
  logic [3:0] lane_err;
  logic wdata_ready;
  logic write_beat;
  psf_pkg::psf_word_t wword;

  assign start = !address_strobe_n || !transfer_start_n;
  assign any_sel = !register_select_n || !pci_window_select_n;
  assign img = image_select ? image1 : image0;
  // A write waits in decode while a delayed write is still open
  assign accept = (state == PSF_DECODE) && any_sel && !(dw_pending && is_write);

  always_comb begin
    is_write = !read_n_write;
    is_burst = !burst_n;
    next_delayed = 1'b0;
    next_req = '0;
    next_req.image = image_select;
    next_req.byte_en = byte_en;
    next_req.io_space = img.pci_space_select;
    next_req.pci_addr = addr;
    if (img.translate_enable) begin
      // Block size picks how many top bits come from the translation base
      for (int b = 16; b < 32; b++) begin
        if (b >= 16 + int'(img.block_size)) begin
          next_req.pci_addr[b] = img.translation_base[b-16];
        end
      end
    end
    if (!register_select_n) begin
      next_req.op = (addr[11:0] == psf_pkg::CFG_CYCLE_OFFSET) ? psf_pkg::PSF_OP_CFG
                                                               : psf_pkg::PSF_OP_REG;
      next_req.pci_addr = addr;
    end else if (is_write) begin
      if (is_burst) begin
        next_req.op = psf_pkg::PSF_OP_BURST_WR;
      end else if (img.posted_write_enable) begin
        next_req.op = psf_pkg::PSF_OP_POSTED_WR;
      end else begin
        next_req.op = psf_pkg::PSF_OP_DELAYED_WR;
        next_delayed = 1'b1;
      end
    end else if (is_burst || (img.prefetch_read_enable && byte_en == 4'hf)) begin
      next_req.op = psf_pkg::PSF_OP_BURST_RD;
    end else begin
      next_req.op = psf_pkg::PSF_OP_SINGLE_RD;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= PSF_IDLE;
    end else begin
      unique case (state)
        PSF_IDLE: begin
          if (start) begin
            state <= PSF_DECODE;
          end
        end
        PSF_DECODE: begin
          // Selects may lag the start strobe, so wait here for them
          if (accept) begin
            state <= PSF_HOLD;
          end else if (!start && !any_sel) begin
            state <= PSF_IDLE;
          end
        end
        PSF_HOLD: begin
          if (req_ready) begin
            state <= PSF_DATA;
          end
        end
        PSF_DATA: begin
          if (cur_write ? (data_valid && wdata_ready) : rd_ack) begin
            // A burst write keeps taking beats while the burst line stays low; a read ends here
            if (burst_n || !cur_write) begin
              state <= PSF_IDLE;
            end
          end
        end
      endcase
    end
  end

  assign req_valid = (state == PSF_HOLD);

  // ==========================================================================
  // Request capture
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      req <= '0;
      cur_write <= 1'b0;
      cur_delayed <= 1'b0;
    end else if (accept) begin
      // Held until the far side takes it, so address and lanes may move on
      req <= next_req;
      cur_write <= is_write;
      cur_delayed <= next_delayed;
    end
  end

  // ==========================================================================
  // Delayed-write interlock
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dw_pending <= 1'b0;
    end else if (state == PSF_HOLD && req_ready && cur_delayed) begin
      dw_pending <= 1'b1;
    end else if (delayed_write_done) begin
      dw_pending <= 1'b0;
    end
  end

  // ==========================================================================
  // Parity check on writes
  for (genvar l = 0; l < psf_pkg::LANES; l++) begin : g_lane
    // Even mode: byte xor line must be 0; odd mode: 1
    assign lane_err[l] = byte_en[l] &&
      ((^wdata[8*l+7:8*l] ^ byte_parity_lines_in[l]) != parity_polarity_select);
  end

  assign write_beat = (state == PSF_DATA) && cur_write && data_valid && wdata_ready;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      proc_parity_err_flag <= 1'b0;
    end else if (write_beat && |lane_err) begin
      // Set beats clear, so an error in the clearing cycle is not lost
      proc_parity_err_flag <= 1'b1;
    end else if (proc_parity_err_clear) begin
      proc_parity_err_flag <= 1'b0;
    end
  end

  // Level outputs that drop as soon as the flag clears
  assign pci_irq = proc_parity_err_flag && proc_parity_err_irq_enable
                   && proc_parity_err_irq_route;
  assign proc_side_irq = proc_parity_err_flag && proc_parity_err_irq_enable
                         && !proc_parity_err_irq_route;

  // ==========================================================================
  // Write data path: the error never stops the beat
  assign wword.data = wdata;
  assign wword.byte_en = byte_en;
  assign wr_ack = write_beat;

  logic sk_valid;
  logic sk_ready;
  psf_pkg::psf_word_t sk_word;
  logic [6:0] pw_lvl;

  // Skid holds beats taken while the FIFO input is full
  psf_skid u_skid (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid((state == PSF_DATA) && cur_write && data_valid),
    .in_ready(wdata_ready),
    .in_word(wword),
    .out_valid(sk_valid),
    .out_ready(sk_ready),
    .out_word(sk_word)
  );

  psf_fifo #(.DEPTH(psf_pkg::PWF_DEPTH), .AW(psf_pkg::PWF_AW)) u_posted_write_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(sk_valid),
    .in_ready(sk_ready),
    .in_word(sk_word),
    .out_valid(pw_valid),
    .out_ready(pw_ready),
    .out_word(pw_word),
    .level(pw_lvl)
  );

  // Fill level lets the far side pace its draining
  assign pw_level = pw_lvl;

  // ==========================================================================
  // Read return path
  logic rf_valid;
  psf_pkg::psf_word_t rf_word;
  logic [3:0] rf_par;
  logic rd_beat;

  // Pop once per read and never in the rd_ack cycle, so a following word is never lost
  assign rd_beat = (state == PSF_DATA) && !cur_write && rf_valid && !rd_ack;

  psf_fifo #(.DEPTH(psf_pkg::RRF_DEPTH), .AW(psf_pkg::RRF_AW)) u_read_return_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(rr_valid),
    .in_ready(rr_ready),
    .in_word(rr_word),
    .out_valid(rf_valid),
    .out_ready(rd_beat),
    .out_word(rf_word),
    .level()
  );

  for (genvar l = 0; l < psf_pkg::LANES; l++) begin : g_rpar
    assign rf_par[l] = ^rf_word.data[8*l+7:8*l] ^ parity_polarity_select;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_ack <= 1'b0;
      byte_parity_lines_oe <= 1'b0;
    end else begin
      rd_ack <= rd_beat;
      byte_parity_lines_oe <= rd_beat;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata <= '0;
      byte_parity_lines_out <= '0;
    end else if (rd_beat) begin
      rdata <= rf_word.data;
      byte_parity_lines_out <= rf_par;
    end
  end
endmodule : psf_frontend

// [pkg/psf_pkg.sv]
// Package: shared constants and carriers for the processor-bus slave front end
package psf_pkg;

  // ==========================================================================
  // Widths and depths
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int PWF_DEPTH = 64;
  localparam int PWF_AW = 6;
  localparam int RRF_DEPTH = 8;
  localparam int RRF_AW = 3;
  localparam int BS_W = 4;
  localparam int TA_W = 16;

  // ==========================================================================
  // Reset values and decode constants
  localparam logic PARITY_POL_RESET = 1'b0;
  localparam logic [11:0] CFG_CYCLE_OFFSET = 12'h504;
  localparam logic [1:0] PROTO_RESET = 2'h0;

  // ==========================================================================
  // Enumerations
  typedef enum logic [1:0] {
    PSF_PROTO_STROBE_TS040 = 2'h0,
    PSF_PROTO_STROBE_TS860 = 2'h1
  } psf_proto_t;

  typedef enum logic [2:0] {
    PSF_OP_REG = 3'h0,
    PSF_OP_CFG = 3'h1,
    PSF_OP_POSTED_WR = 3'h2,
    PSF_OP_DELAYED_WR = 3'h3,
    PSF_OP_SINGLE_RD = 3'h4,
    PSF_OP_BURST_RD = 3'h5,
    PSF_OP_BURST_WR = 3'h6
  } psf_op_t;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic pci_space_select;
    logic posted_write_enable;
    logic prefetch_read_enable;
    logic translate_enable;
    logic [BS_W-1:0] block_size;
    logic [TA_W-1:0] translation_base;
  } psf_image_t;

  typedef struct packed {
    psf_op_t op;
    logic image;
    logic io_space;
    logic [DATA_W-1:0] pci_addr;
    logic [LANES-1:0] byte_en;
  } psf_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [LANES-1:0] byte_en;
  } psf_word_t;

endpackage : psf_pkg

// [rtl/psf_skid.sv]
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module psf_skid (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire psf_pkg::psf_word_t in_word,
  output logic out_valid,
  input wire logic out_ready,
  output psf_pkg::psf_word_t out_word
);
  // ==========================================================================
  // Storage
  psf_pkg::psf_word_t slot [2];
  logic [1:0] count;
  logic rd_ptr;
  logic wr_ptr;
  logic push;
  logic pop;

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_word = slot[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      slot[wr_ptr] <= in_word;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      count <= 2'h0;
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : psf_skid

// [rtl/psf_fifo.sv]
// Synchronous FIFO used for posted writes and read return data
`timescale 1ns/1ps
module psf_fifo #(
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire psf_pkg::psf_word_t in_word,
  output logic out_valid,
  input wire logic out_ready,
  output psf_pkg::psf_word_t out_word,
  output logic [AW:0] level
);
  // ==========================================================================
  // Storage
  psf_pkg::psf_word_t mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic push;
  logic pop;

  assign in_ready = (level != (AW+1)'(DEPTH));
  assign out_valid = (level != '0);
  assign out_word = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_word;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      level <= level + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : psf_fifo

// [bench/psf_frontend_monitor.sv]
// Port checker for the slave front end
`timescale 1ns/1ps
module psf_frontend_monitor (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic register_select_n,
  input wire logic pci_window_select_n,
  input wire logic image_select,
  input wire logic [31:0] addr,
  input wire logic [31:0] rdata,
  input wire logic [3:0] byte_parity_lines_out,
  input wire logic byte_parity_lines_oe,
  input wire logic rd_ack,
  input wire logic slave_protocol_strap,
  input wire logic parity_polarity_select,
  input wire logic proc_parity_err_irq_enable,
  input wire logic proc_parity_err_irq_route,
  input wire logic proc_parity_err_clear,
  input wire logic proc_parity_err_flag,
  input wire logic pci_irq,
  input wire logic proc_side_irq,
  input wire logic [1:0] slave_protocol,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire psf_pkg::psf_req_t req,
  input wire logic [6:0] pw_level
);
  // ====================
  // Helpers
  logic irq_on;
  assign irq_on = proc_parity_err_flag && proc_parity_err_irq_enable;
  function automatic logic [3:0] lane_par(input logic [31:0] d, input logic odd);
    lane_par = {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]} ^ {4{odd}};
  endfunction : lane_par
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // ====================
  // Assertions
  a_irq_route: assert property ({pci_irq, proc_side_irq} ==
    (irq_on ? {proc_parity_err_irq_route, !proc_parity_err_irq_route} : 2'h0))
    else $error("interrupt routing wrong");
  a_flag_hold: assert property (
    proc_parity_err_flag && !proc_parity_err_clear |=> proc_parity_err_flag)
    else $error("flag lost without clear");
  a_rd_oe: assert property (byte_parity_lines_oe == rd_ack)
    else $error("parity drive not with read ack");
  a_rd_parity: assert property (rd_ack |->
    byte_parity_lines_out == lane_par(rdata, parity_polarity_select))
    else $error("read parity wrong");
  a_req_hold: assert property (
    req_valid && !req_ready |=> req_valid && $stable(req))
    else $error("request dropped or changed");
  a_req_cause: assert property ($rose(req_valid) |->
    $past(!register_select_n || !pci_window_select_n))
    else $error("request without chip select");
  a_img_pick: assert property (
    $rose(req_valid) && !$past(pci_window_select_n) |-> req.image == $past(image_select))
    else $error("wrong image");
  a_cfg_decode: assert property ($rose(req_valid) &&
    $past(!register_select_n && addr[11:0] == 12'h504) |-> req.op == psf_pkg::PSF_OP_CFG)
    else $error("config offset not decoded");
  a_pw_cap: assert property (pw_level <= 7'h40)
    else $error("posted fifo overfilled");
  a_proto_latch: assert property (
    $rose(rst_n) |=> slave_protocol == {1'b0, $past(slave_protocol_strap)})
    else $error("protocol not latched");
  c_read: cover property (rd_ack);
  c_perr: cover property ($rose(proc_parity_err_flag));
  c_full: cover property (pw_level == 7'h40);
endmodule : psf_frontend_monitor
bind psf_frontend psf_frontend_monitor mon (.*);

// [bench/psf_pci_model.sv]
// Model of the PCI master side of the slave channel
`timescale 1ns/1ps
module psf_pci_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic [31:0] rd_data,
  input wire logic req_valid,
  output logic req_ready,
  input wire psf_pkg::psf_req_t req,
  output logic delayed_write_done,
  input wire logic pw_valid,
  output logic pw_ready,
  input wire psf_pkg::psf_word_t pw_word,
  output logic [31:0] pw_seen,
  output logic rr_valid,
  input wire logic rr_ready,
  output psf_pkg::psf_word_t rr_word
);
  logic [3:0] dly;
  logic pend;
  logic take;
  assign take = req_valid && req_ready;
  // ====================
  // Slow accept so decode sees back-pressure
  always_ff @(posedge clk_sys) begin
    if (!rst_n || req_ready) begin
      req_ready <= 1'b0;
      dly <= 4'h0;
    end else if (req_valid) begin
      dly <= dly + 4'h1;
      req_ready <= (dly == 4'h2);
    end
  end
  // ====================
  // Delayed write completes when its word reaches PCI
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pend <= 1'b0;
      delayed_write_done <= 1'b0;
    end else begin
      delayed_write_done <= pend && pw_valid && pw_ready;
      if (take && req.op == psf_pkg::PSF_OP_DELAYED_WR) pend <= 1'b1;
      else if (pw_valid && pw_ready) pend <= 1'b0;
    end
  end
  // ====================
  // Drain at half rate, stops entirely while stalled
  always_ff @(posedge clk_sys) begin
    if (!rst_n) pw_ready <= 1'b0;
    else pw_ready <= !stall && !pw_ready;
  end
  always_ff @(posedge clk_sys) begin
    if (pw_valid && pw_ready) pw_seen <= pw_word.data;
  end
  // ====================
  // Read return; a released word is inverted so it never looks current
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rr_valid <= 1'b0;
      rr_word <= '0;
    end else if (rr_valid && rr_ready) begin
      rr_valid <= 1'b0;
      rr_word <= ~rr_word;
    end else if (take && (req.op == psf_pkg::PSF_OP_SINGLE_RD ||
        req.op == psf_pkg::PSF_OP_BURST_RD)) begin
      rr_valid <= 1'b1;
      rr_word <= {rd_data, 4'hf};
    end
  end
endmodule : psf_pci_model

// [bench/psf_frontend_tb.sv]
// Self-checking bench for the slave front end
`timescale 1ns/1ps
module psf_frontend_tb;
  logic clk_sys = 1'b0, rst_n = 1'b0, stall = 1'b0;
  logic address_strobe_n = 1'b1, transfer_start_n = 1'b1, burst_n = 1'b1;
  logic register_select_n = 1'b1, pci_window_select_n = 1'b1, image_select = 1'b0;
  logic read_n_write = 1'b0, data_valid = 1'b0, slave_protocol_strap = 1'b0;
  logic parity_polarity_select = 1'b0, proc_parity_err_clear = 1'b0;
  logic proc_parity_err_irq_enable = 1'b0, proc_parity_err_irq_route = 1'b0;
  logic [31:0] addr = 32'h0, wdata = 32'h0, rd_data = 32'h0;
  logic [3:0] byte_en = 4'h0, byte_parity_lines_in = 4'h0;
  // Image 0 posts writes, image 1 delays writes and prefetches reads
  psf_pkg::psf_image_t image0 = 24'h400000, image1 = 24'h200000;
  logic [31:0] rdata, pw_seen;
  logic [3:0] byte_parity_lines_out;
  logic byte_parity_lines_oe, wr_ack, rd_ack, proc_parity_err_flag, pci_irq;
  logic proc_side_irq, req_valid, req_ready, delayed_write_done, pw_valid, pw_ready;
  logic rr_valid, rr_ready;
  logic [1:0] slave_protocol;
  logic [6:0] pw_level;
  psf_pkg::psf_req_t req;
  psf_pkg::psf_word_t pw_word, rr_word;
  int n_errors = 0, n_tests = 0;
  always #2 clk_sys = ~clk_sys;
  psf_frontend uut (.*);
  psf_pci_model partner (.*);
  // ====================
  // Tasks
  task automatic give_verdict();
    if (n_errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [3:0] lane_par(input logic [31:0] d, input logic odd);
    lane_par = {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]} ^ {4{odd}};
  endfunction : lane_par
  function automatic logic hit(input int w);
    case (w)
      0: hit = req_valid;
      1: hit = wr_ack;
      2: hit = rd_ack;
      default: hit = (pw_level == 7'h40);
    endcase
  endfunction : hit
  // Returns one edge after the event so the handshake edge has passed
  task automatic waitfor(input int w);
    int k;
    for (k = 0; k < 300; k++) begin
      #1;
      if (hit(w) === 1'b1) break;
      @(negedge clk_sys);
    end
    if (k == 300) begin
      chk(32'h0, 32'h1);
      give_verdict();
    end
    @(negedge clk_sys);
  endtask : waitfor
  task automatic cyc(input logic rs, input logic rd, input logic img, input int nb,
      input logic [31:0] a, input logic [3:0] be, input logic [3:0] bad,
      input logic [2:0] eo);
    {address_strobe_n, transfer_start_n, read_n_write, image_select} = {2'h0, rd, img};
    burst_n = (nb == 1);
    addr = a;
    byte_en = be;
    @(negedge clk_sys);
    {address_strobe_n, transfer_start_n} = 2'h3;
    {register_select_n, pci_window_select_n} = {!rs, rs};
    waitfor(0);
    chk(req.op, eo);
    {register_select_n, pci_window_select_n} = 2'h3;
    if (rd) waitfor(2);
    else for (int i = 0; i < nb; i++) begin
      wdata = a + i;
      byte_parity_lines_in = lane_par(a + i, parity_polarity_select) ^ bad;
      burst_n = (i == nb - 1);
      data_valid = 1'b1;
      waitfor(1);
    end
    data_valid = 1'b0;
    burst_n = 1'b1;
    @(negedge clk_sys);
  endtask : cyc
  // ====================
  // Sequence
  initial begin
    for (int p = 1; p >= 0; p--) begin
      slave_protocol_strap = p[0];
      rst_n = 1'b0;
      repeat (10) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (2) @(negedge clk_sys);
      chk(slave_protocol, p);
    end
    chk(proc_parity_err_flag, 0);
    cyc(0, 0, 0, 1, 32'h10000010, 4'hf, 4'h0, psf_pkg::PSF_OP_POSTED_WR);
    cyc(0, 0, 1, 1, 32'h10000020, 4'hf, 4'h0, psf_pkg::PSF_OP_DELAYED_WR);
    cyc(0, 0, 0, 1, 32'h10000030, 4'hf, 4'h0, psf_pkg::PSF_OP_POSTED_WR);
    cyc(0, 0, 0, 3, 32'h10000040, 4'hf, 4'h0, psf_pkg::PSF_OP_BURST_WR);
    cyc(1, 0, 0, 1, 32'h00000504, 4'hf, 4'h0, psf_pkg::PSF_OP_CFG);
    cyc(1, 0, 0, 1, 32'h00000100, 4'hf, 4'h0, psf_pkg::PSF_OP_REG);
    chk(proc_parity_err_flag, 0);
    cyc(0, 0, 0, 1, 32'h000000ff, 4'h8, 4'h7, psf_pkg::PSF_OP_POSTED_WR);
    chk(proc_parity_err_flag, 0);
    cyc(0, 0, 0, 1, 32'h81000000, 4'h8, 4'h8, psf_pkg::PSF_OP_POSTED_WR);
    repeat (6) @(negedge clk_sys);
    chk(proc_parity_err_flag, 1);
    chk(pw_seen, 32'h81000000);
    for (int m = 0; m < 4; m++) begin
      {proc_parity_err_irq_enable, proc_parity_err_irq_route} = m[1:0];
      @(negedge clk_sys);
      chk({pci_irq, proc_side_irq}, {m[1] & m[0], m[1] & !m[0]});
    end
    chk(proc_parity_err_flag, 1);
    proc_parity_err_clear = 1'b1;
    @(negedge clk_sys);
    proc_parity_err_clear = 1'b0;
    @(negedge clk_sys);
    chk({proc_parity_err_flag, pci_irq}, 0);
    parity_polarity_select = 1'b1;
    cyc(0, 0, 0, 1, 32'h12345678, 4'hf, 4'h0, psf_pkg::PSF_OP_POSTED_WR);
    chk(proc_parity_err_flag, 0);
    cyc(0, 0, 0, 1, 32'h12345678, 4'h1, 4'h1, psf_pkg::PSF_OP_POSTED_WR);
    repeat (4) @(negedge clk_sys);
    chk(proc_parity_err_flag, 1);
    for (int q = 0; q < 2; q++) begin
      parity_polarity_select = q[0];
      rd_data = 32'h5a3c9601 + q;
      cyc(0, 1, 1, 1, 32'h20000000, 4'hf, 4'h0, psf_pkg::PSF_OP_BURST_RD);
      chk(rdata, rd_data);
      rd_data = ~rd_data;
      cyc(0, 1, 0, 1, 32'h20000004, 4'hf, 4'h0, psf_pkg::PSF_OP_SINGLE_RD);
      chk(rdata, rd_data);
    end
    stall = 1'b1;
    fork
      cyc(0, 0, 0, 68, 32'h30000000, 4'hf, 4'h0, psf_pkg::PSF_OP_BURST_WR);
      begin
        waitfor(3);
        chk(pw_level, 64);
        stall = 1'b0;
      end
    join
    repeat (200) @(negedge clk_sys);
    chk(pw_level, 0);
    {address_strobe_n, transfer_start_n} = 2'h0;
    @(negedge clk_sys);
    {address_strobe_n, transfer_start_n} = 2'h3;
    repeat (8) begin
      @(negedge clk_sys);
      chk(req_valid, 0);
    end
    rd_data = 32'h0f1e2d3c;
    {address_strobe_n, transfer_start_n, pci_window_select_n, read_n_write} = 4'h1;
    @(negedge clk_sys);
    {address_strobe_n, transfer_start_n} = 2'h3;
    waitfor(0);
    chk(req.op, psf_pkg::PSF_OP_SINGLE_RD);
    pci_window_select_n = 1'b1;
    waitfor(2);
    chk(rdata, rd_data);
    give_verdict();
  end
endmodule : psf_frontend_tb
